// file: hdl/fcs_pkg.sv
// Purpose: Shared constants for the flash checksum scanner
// Assumes: AHB-Lite register bus, 32-bit data, one register per word
// Notes:   Register offsets 0x00..0x02 are indices; byte address is index times four
package fcs_pkg;
  // Register indices and byte address shift
  localparam logic [1:0]  FCS_IDX_CTRL_A  = 2'h0;
  localparam logic [1:0]  FCS_IDX_CTRL_B  = 2'h1;
  localparam logic [1:0]  FCS_IDX_STATUS  = 2'h2;
  localparam int          FCS_ADDR_SHIFT  = 2;
  // Control A fields
  localparam int          FCS_A_RESET_BIT = 7;
  localparam int          FCS_A_FAIL_INTERRUPT_ENABLE_BIT = 1;
  localparam int          FCS_A_EN_BIT    = 0;
  // Control B fields
  localparam int          FCS_B_MODE_LSB  = 4;
  localparam int          FCS_B_SRC_LSB   = 0;
  // Status fields
  localparam int          FCS_S_PASS_BIT  = 1;
  localparam int          FCS_S_BUSY_BIT  = 0;
  // Reset values
  localparam logic [7:0]  FCS_CTRL_A_RST  = 8'h00;
  localparam logic [7:0]  FCS_CTRL_B_RST  = 8'h00;
  localparam logic        FCS_PASS_RST    = 1'b1;
  // Section select codes
  localparam logic [1:0]  FCS_SRC_FLASH   = 2'h0;
  localparam logic [1:0]  FCS_SRC_BOOT_PLUS_CODE_SECTION = 2'h1;
  localparam logic [1:0]  FCS_SRC_BOOT    = 2'h2;
  // Timing counts
  localparam logic [1:0]  FCS_START_DLY   = 2'h3;
  localparam logic [1:0]  FCS_FETCH_DIV   = 2'h3;
  // Checksum engine
  localparam logic [15:0] FCS_CRC_INIT    = 16'hFFFF;
  localparam logic [15:0] FCS_CRC_POLY    = 16'h1021;
  localparam int          FCS_PAGE_SHIFT  = 8;
  // Scanner states
  typedef enum logic [3:0] {
    FCS_IDLE  = 4'b0001,
    FCS_DELAY = 4'b0010,
    FCS_SCAN  = 4'b0100,
    FCS_DONE  = 4'b1000
  } fcs_state_t;
endpackage

// file: hdl/fcs_crc16.sv
// Purpose: One-byte CCITT checksum step
// Assumes: Byte shifted in most significant bit first
// Notes:   Purely combinational
`timescale 1ns/10ps
`default_nettype none
module fcs_crc16
  import fcs_pkg::*;
(
  input  wire logic [15:0] crc_in,
  input  wire logic [7:0]  data_in,
  output logic      [15:0] crc_out
);
  // Serial shift unrolled over eight bits
  always_comb begin
    logic [15:0] c;
    c = crc_in;
    for (int i = 7; i >= 0; i--) begin
      if (c[15] ^ data_in[i]) begin
        c = {c[14:0], 1'b0} ^ FCS_CRC_POLY; // see RQ23 see RQ24
      end else begin
        c = {c[14:0], 1'b0};
      end
    end
    crc_out = c;
  end
endmodule
`default_nettype wire

// file: hdl/fcs_ahb_slave.sv
// Purpose: AHB-Lite slave front end for the scanner registers
// Assumes: Single word transfers only, zero wait states
// Notes:   Write strobe is issued in the data phase with the captured index
`timescale 1ns/10ps
`default_nettype none
module fcs_ahb_slave
  import fcs_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic        hready,
  input  wire logic [31:0] hwdata,
  output logic             hreadyout,
  output logic             hresp,
  output logic      [31:0] hrdata,
  input  wire logic [7:0]  rd_word [3],
  output logic             wr_stb,
  output logic      [1:0]  wr_idx,
  output logic      [7:0]  wr_data
);
  logic       pend_r, pend_nxt;
  logic [1:0] idx_r, idx_nxt;
  logic       mapped;

  // Address phase capture
  always_comb begin
    idx_nxt  = idx_r;
    pend_nxt = 1'b0;
    if (hsel && hready && htrans[1]) begin
      idx_nxt  = haddr[FCS_ADDR_SHIFT +: 2];
      pend_nxt = hwrite;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pend_r <= 1'b0;
      idx_r  <= 2'h0;
    end else begin
      pend_r <= pend_nxt;
      idx_r  <= idx_nxt;
    end
  end

  // Unmapped word reads zero, writes ignored
  assign mapped    = (idx_r != 2'h3);
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = mapped ? {24'h00_0000, rd_word[idx_r]} : 32'h0000_0000;
  assign wr_stb    = pend_r && mapped;
  assign wr_idx    = idx_r;
  assign wr_data   = hwdata[7:0];
endmodule
`default_nettype wire

// file: hdl/fcs_scanner.sv
// Purpose: Flash checksum scanner with stall, debug and failure interrupt
// Assumes: Flash returns a 16-bit word one cycle after a fetch request
// Notes:   Words hold the lower byte address in bits 15:8 (byte zero first)
`timescale 1ns/10ps
`default_nettype none
// Contract
// RQ1: Start scanning three cycles after enable write
// RQ2: Failed boot scan holds CPU, flags show it
// RQ3: Passed boot scan releases CPU, flags set
// RQ4: Scanner owns flash, stalls CPU until done
// RQ5: Fetch one word every third cycle
// RQ6: Stored checksum occupies section's last two bytes
// RQ7: Checksum mismatch clears pass flag
// RQ8: Pass flag cleared with enable raises NMI
// RQ9: NMI request held until system reset
// RQ10: Halt during sleep, resume on wake
// RQ11: Sleep in delay defers start and interrupts
// RQ12: Debugger access disables; restart on register/disconnect
// RQ13: Busy kept while held; status read re-enables
// RQ14: Debug busy write zero aborts, one starts
// RQ15: Busy blocks section and enable changes
// RQ16: Debug pass-zero write triggers NMI, locks writes
// RQ17: Debug pass-one write sets flag when idle
// RQ18: Reset strobe clears registers next cycle
// RQ19: Strobe blocked while busy if interrupt enabled
// RQ20: Interrupt enable set only idle, sysreset clears
// RQ21: Enable sticks; rewrite restarts, zero ignored
// RQ22: Fixed bit positions in control and status
// RQ23: CCITT polynomial x16+x12+x5+1
// RQ24: Bytes from zero, most significant bit first
// RQ25: Checksum starts at all ones
// RQ26: Section codes: whole, boot+code, boot
// RQ27: Busy spans scan; pass updated at end
module fcs_scanner
  import fcs_pkg::*;
#(
  parameter int AW = 16
)(
  input  wire logic          hclk,
  input  wire logic          hresetn,
  input  wire logic          hsel,
  input  wire logic [31:0]   haddr,
  input  wire logic [1:0]    htrans,
  input  wire logic          hwrite,
  input  wire logic [2:0]    hsize,
  input  wire logic          hready,
  input  wire logic [31:0]   hwdata,
  output logic               hreadyout,
  output logic               hresp,
  output logic      [31:0]   hrdata,
  input  wire logic          boot_scan_en,
  input  wire logic [1:0]    boot_scan_section_fuse,
  input  wire logic [7:0]    boot_end_fuse,
  input  wire logic [7:0]    app_end_fuse,
  input  wire logic [AW-1:0] last_flash_address,
  input  wire logic          cpu_sleep,
  input  wire logic          dbg_mem_access,
  input  wire logic          dbg_reg_access,
  input  wire logic          dbg_disconnect,
  input  wire logic          dbg_status_read,
  input  wire logic          dbg_wr_stb,
  input  wire logic [1:0]    dbg_wr_idx,
  input  wire logic [7:0]    dbg_wr_data,
  output logic      [1:0]    dbg_status,
  output logic               flash_req,
  output logic      [AW-1:0] flash_addr,
  input  wire logic [15:0]   flash_rdata,
  output logic               cpu_stall,
  output logic               irq_hold,
  output logic               nmi_req
);
  logic [7:0]    rd_word [3];
  logic          bus_stb;
  logic [1:0]    bus_idx;
  logic [7:0]    bus_data;
  logic [15:0]   crc_a, crc_b, crc_c;

  fcs_state_t    st_r, st_nxt;
  logic          en_r, en_nxt;
  logic          fail_interrupt_enable_r, fail_interrupt_enable_nxt;
  logic [1:0]    mode_r, mode_nxt;
  logic [1:0]    src_r, src_nxt;
  logic          busy_r, busy_nxt;
  logic          pass_r, pass_nxt;
  logic          nmi_r, nmi_nxt;
  logic          clr_r, clr_nxt;
  logic          boot_r, boot_nxt;
  logic          boot_pend_r, boot_pend_nxt;
  logic          hold_r, hold_nxt;
  logic [1:0]    cnt_r, cnt_nxt;
  logic [AW-1:0] addr_r, addr_nxt;
  logic          rvalid_r, rvalid_nxt;
  logic [15:0]   crc_r, crc_nxt;
  logic [15:0]   last_r, last_nxt;
  logic          fail_hang_r, fail_hang_nxt; // Failed reset-time scan keeps the CPU off
  logic [AW-1:0] end_addr;
  logic [2:0]    sl_s1_r, sl_s2_r;
  logic          sleep_s, dbg_mem_s, dbg_rel_s;

  // Sleep and debugger access pins cross two stages first; debugger register writes go straight in
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sl_s1_r <= 3'h0;
      sl_s2_r <= 3'h0;
    end else begin
      sl_s1_r <= {cpu_sleep, dbg_mem_access, dbg_reg_access | dbg_disconnect | dbg_status_read};
      sl_s2_r <= sl_s1_r;
    end
  end
  assign sleep_s   = sl_s2_r[2];
  assign dbg_mem_s = sl_s2_r[1];
  assign dbg_rel_s = sl_s2_r[0];

  fcs_ahb_slave u_bus (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .hsel      (hsel),
    .haddr     (haddr),
    .htrans    (htrans),
    .hwrite    (hwrite),
    .hready    (hready),
    .hwdata    (hwdata),
    .hreadyout (hreadyout),
    .hresp     (hresp),
    .hrdata    (hrdata),
    .rd_word   (rd_word),
    .wr_stb    (bus_stb),
    .wr_idx    (bus_idx),
    .wr_data   (bus_data)
  );

  // Two byte steps per fetched word, upper byte holds the lower address
  fcs_crc16 u_crc_hi (
    .crc_in  (crc_r),
    .data_in (flash_rdata[15:8]),
    .crc_out (crc_a)
  );
  fcs_crc16 u_crc_lo (
    .crc_in  (crc_a),
    .data_in (flash_rdata[7:0]),
    .crc_out (crc_b)
  );
  assign crc_c = crc_b;

  // Word address of the last word of the chosen section
  always_comb begin
    case (src_r)
      FCS_SRC_BOOT:    end_addr = AW'(({8'h00, boot_end_fuse} << FCS_PAGE_SHIFT) - 16'h0002);
      FCS_SRC_BOOT_PLUS_CODE_SECTION: end_addr = AW'(({8'h00, app_end_fuse} << FCS_PAGE_SHIFT) - 16'h0002);
      default:         end_addr = last_flash_address - AW'(1); // see RQ6 see RQ26
    endcase
  end

  // Register read view
  assign rd_word[FCS_IDX_CTRL_A] = {6'h00, fail_interrupt_enable_r, en_r}; // see RQ22
  assign rd_word[FCS_IDX_CTRL_B] = {2'h0, mode_r, 2'h0, src_r};
  assign rd_word[FCS_IDX_STATUS] = {6'h00, pass_r, busy_r};
  assign dbg_status = {pass_r, busy_r};

  // Control, status and scan sequencing
  always_comb begin
    logic       wr;
    logic [1:0] wi;
    logic [7:0] wd;
    logic       dbg;
    logic       hw_fail;
    hw_fail       = 1'b0;
    st_nxt        = st_r;
    en_nxt        = en_r;
    fail_interrupt_enable_nxt     = fail_interrupt_enable_r;
    mode_nxt      = mode_r;
    src_nxt       = src_r;
    busy_nxt      = busy_r;
    pass_nxt      = pass_r;
    nmi_nxt       = nmi_r;
    clr_nxt       = 1'b0;
    boot_nxt      = boot_r;
    boot_pend_nxt = 1'b0;
    hold_nxt      = hold_r;
    cnt_nxt       = cnt_r;
    addr_nxt      = addr_r;
    rvalid_nxt    = 1'b0;
    crc_nxt       = crc_r;
    last_nxt      = last_r;
    fail_hang_nxt = fail_hang_r;
    dbg           = dbg_wr_stb;
    wr            = (dbg_wr_stb | bus_stb) & ~nmi_r; // see RQ16
    wi            = dbg_wr_stb ? dbg_wr_idx : bus_idx;
    wd            = dbg_wr_stb ? dbg_wr_data : bus_data;
    // Debugger memory access freezes; register touch or disconnect restarts
    if (dbg_mem_s) begin
      hold_nxt = 1'b1; // see RQ12 see RQ13
    end else if (hold_r && dbg_rel_s) begin
      hold_nxt = 1'b0;
      if (busy_r) begin
        st_nxt = FCS_DELAY; // see RQ12
        cnt_nxt = 2'h0;
      end
    end
    // Reset-time scan armed once after release
    if (boot_pend_r && boot_scan_en) begin
      en_nxt   = 1'b1;
      src_nxt  = boot_scan_section_fuse;
      busy_nxt = 1'b1;
      boot_nxt = 1'b1;
      st_nxt   = FCS_DELAY;
      cnt_nxt  = FCS_START_DLY - 2'h1;
    end
    // Sequencer stops while sleeping or held by the debugger
    if (!sleep_s && !hold_r) begin // see RQ10 see RQ11 see RQ13
      case (st_r)
        FCS_IDLE: begin
          cnt_nxt = 2'h0;
        end
        FCS_DELAY: begin
          if (cnt_r == FCS_START_DLY - 2'h1) begin
            st_nxt   = FCS_SCAN; // see RQ1
            cnt_nxt  = 2'h0;
            addr_nxt = '0;
            crc_nxt  = FCS_CRC_INIT; // see RQ25
          end else begin
            cnt_nxt = cnt_r + 2'h1;
          end
        end
        FCS_SCAN: begin
          rvalid_nxt = (cnt_r == 2'h0);
          cnt_nxt = (cnt_r == FCS_FETCH_DIV - 2'h1) ? 2'h0 : cnt_r + 2'h1; // see RQ5
          if (rvalid_r) begin
            if (addr_r == end_addr) begin
              last_nxt = flash_rdata;
              st_nxt   = FCS_DONE;
            end else begin
              crc_nxt  = crc_c; // see RQ24
              addr_nxt = addr_r + AW'(2);
            end
          end
        end
        FCS_DONE: begin
          busy_nxt = 1'b0; // see RQ27
          boot_nxt = 1'b0;
          st_nxt   = FCS_IDLE;
          if (crc_r == last_r) begin
            pass_nxt = 1'b1; // see RQ3
          end else begin
            pass_nxt = 1'b0; // see RQ7 see RQ2
            hw_fail  = 1'b1;
          end
          if (boot_r) begin
            fail_hang_nxt = hw_fail; // see RQ2
          end
        end
        default: st_nxt = FCS_IDLE;
      endcase
    end
    // Register writes
    if (wr) begin
      case (wi)
        FCS_IDX_CTRL_A: begin
          if (wd[FCS_A_RESET_BIT] && (!fail_interrupt_enable_r || !busy_r)) begin
            clr_nxt = 1'b1; // see RQ18 see RQ19
          end
          if (wd[FCS_A_FAIL_INTERRUPT_ENABLE_BIT] && !busy_r) begin
            fail_interrupt_enable_nxt = 1'b1; // see RQ15 see RQ20
          end
          if (wd[FCS_A_EN_BIT]) begin
            en_nxt   = 1'b1; // see RQ21
            busy_nxt = 1'b1;
            st_nxt   = FCS_DELAY;
            cnt_nxt  = 2'h0;
          end
        end
        FCS_IDX_CTRL_B: begin
          if (!busy_r) begin
            mode_nxt = wd[FCS_B_MODE_LSB +: 2]; // see RQ15
            src_nxt  = wd[FCS_B_SRC_LSB +: 2];
          end
        end
        FCS_IDX_STATUS: begin
          if (dbg) begin
            if (!wd[FCS_S_BUSY_BIT]) begin
              busy_nxt = 1'b0; // see RQ14
              st_nxt   = FCS_IDLE;
            end else if (!busy_r) begin
              busy_nxt = 1'b1; // see RQ14
              st_nxt   = FCS_DELAY;
              cnt_nxt  = 2'h0;
            end
            if (!wd[FCS_S_PASS_BIT]) begin
              pass_nxt = 1'b0; // see RQ16
            end else if (!busy_nxt && !hw_fail) begin // Hardware failure wins
              pass_nxt = 1'b1; // see RQ17
            end
          end
        end
        default: ;
      endcase
    end
    // Strobe clears the three registers a cycle later, interrupt enable survives
    if (clr_r) begin
      en_nxt   = 1'b0; // see RQ18 see RQ20
      mode_nxt = 2'h0;
      src_nxt  = 2'h0;
      busy_nxt = 1'b0;
      pass_nxt = 1'b0;
      st_nxt   = FCS_IDLE;
    end
    // Pass flag falling with interrupt enabled latches the request
    if (pass_r && !pass_nxt && fail_interrupt_enable_nxt) begin
      nmi_nxt = 1'b1; // see RQ8 see RQ9
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_r        <= FCS_IDLE;
      en_r        <= FCS_CTRL_A_RST[FCS_A_EN_BIT];
      fail_interrupt_enable_r     <= FCS_CTRL_A_RST[FCS_A_FAIL_INTERRUPT_ENABLE_BIT];
      mode_r      <= FCS_CTRL_B_RST[FCS_B_MODE_LSB +: 2];
      src_r       <= FCS_CTRL_B_RST[FCS_B_SRC_LSB +: 2];
      busy_r      <= 1'b0;
      pass_r      <= FCS_PASS_RST;
      nmi_r       <= 1'b0;
      clr_r       <= 1'b0;
      boot_r      <= 1'b0;
      boot_pend_r <= 1'b1;
      hold_r      <= 1'b0;
      cnt_r       <= 2'h0;
      addr_r      <= '0;
      rvalid_r    <= 1'b0;
      crc_r       <= FCS_CRC_INIT;
      last_r      <= 16'h0000;
      fail_hang_r <= 1'b0;
    end else begin
      st_r        <= st_nxt;
      en_r        <= en_nxt;
      fail_interrupt_enable_r     <= fail_interrupt_enable_nxt;
      mode_r      <= mode_nxt;
      src_r       <= src_nxt;
      busy_r      <= busy_nxt;
      pass_r      <= pass_nxt;
      nmi_r       <= nmi_nxt;
      clr_r       <= clr_nxt;
      boot_r      <= boot_nxt;
      boot_pend_r <= boot_pend_nxt;
      hold_r      <= hold_nxt;
      cnt_r       <= cnt_nxt;
      addr_r      <= addr_nxt;
      rvalid_r    <= rvalid_nxt;
      crc_r       <= crc_nxt;
      last_r      <= last_nxt;
      fail_hang_r <= fail_hang_nxt;
    end
  end

  // Flash port and CPU control
  assign flash_req  = (st_r == FCS_SCAN) && (cnt_r == 2'h0) && !sleep_s && !hold_r; // see RQ4
  assign flash_addr = addr_r;
  // Stall once scanning, through a reset-time scan and after its failure; other delay cycles let the CPU run
  assign cpu_stall  = (st_r == FCS_SCAN) || (st_r == FCS_DONE) || boot_r
                      || fail_hang_r; // see RQ1 see RQ2 see RQ4
  assign irq_hold   = busy_r && (st_r != FCS_IDLE); // see RQ11
  assign nmi_req    = nmi_r; // see RQ9
endmodule
`default_nettype wire

// file: bench/fcs_props.sv
// Purpose: Port-level properties of the checksum scanner
// Assumes: One clock domain, reset active low
// Notes:   Sees a subset of the scanner ports; bound below
`timescale 1ns/10ps
`default_nettype none
module fcs_props
  import fcs_pkg::*;
(
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic [31:0] hwdata,
  input wire logic        cpu_sleep,
  input wire logic        dbg_mem_access,
  input wire logic [1:0]  dbg_status,
  input wire logic        flash_req,
  input wire logic        cpu_stall,
  input wire logic        nmi_req
);
  logic a_ph_r;
  logic a_ph_nxt;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // Data phase of a control A write follows this address phase
  always_comb begin
    a_ph_nxt = hsel && hready && htrans[1] && hwrite && (haddr[3:2] == FCS_IDX_CTRL_A);
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      a_ph_r <= 1'b0;
    end else begin
      a_ph_r <= a_ph_nxt;
    end
  end
  // Idle, unlocked writes only; busy or locked writes behave otherwise
  sequence en_wr_s;
    a_ph_r && hwdata[FCS_A_EN_BIT] && !dbg_status[0] && !nmi_req;
  endsequence
  sequence rst_wr_s;
    a_ph_r && hwdata[FCS_A_RESET_BIT] && !dbg_status[0] && !nmi_req;
  endsequence
  AST_START_DELAY: assert property (en_wr_s |=> (!flash_req && !cpu_stall) [*3])
    else $error("fetch or stall in start delay");
  AST_FETCH_GAP: assert property (flash_req |=> !flash_req [*2])
    else $error("fetches too close");
  AST_STALL_FETCH: assert property (flash_req |-> cpu_stall)
    else $error("fetch without stall");
  AST_IDLE_QUIET: assert property (!dbg_status[0] |-> !flash_req)
    else $error("fetch while not busy");
  AST_NMI_HOLD: assert property (nmi_req |=> nmi_req)
    else $error("nmi withdrawn");
  AST_NMI_CAUSE: assert property ($rose(nmi_req) |-> !dbg_status[1])
    else $error("nmi with pass set");
  AST_SLEEP_HALT: assert property (cpu_sleep [*5] |-> !flash_req)
    else $error("fetch during sleep");
  AST_DBG_HALT: assert property (dbg_mem_access [*5] |-> !flash_req)
    else $error("fetch during debug access");
  AST_STROBE_CLR: assert property (rst_wr_s |-> ##[1:2] (dbg_status == 2'h0))
    else $error("strobe did not clear status");
endmodule
bind fcs_scanner fcs_props fcs_props_inst (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hready(hready), .hwdata(hwdata), .cpu_sleep(cpu_sleep),
  .dbg_mem_access(dbg_mem_access), .dbg_status(dbg_status), .flash_req(flash_req),
  .cpu_stall(cpu_stall), .nmi_req(nmi_req)
);
`default_nettype wire

// file: bench/fcs_flash_model.sv
// Purpose: Behavioural flash array answering scanner fetches
// Assumes: Word due one cycle after the request, lower address in the high byte
// Notes:   Idle data lines toggle so stale data never looks valid
`timescale 1ns/10ps
`default_nettype none
module fcs_flash_model #(
  parameter int AW    = 16,
  parameter int DEPTH = 1024
)(
  input  wire logic          hclk,
  input  wire logic          flash_req,
  input  wire logic [AW-1:0] flash_addr,
  output logic      [15:0]   flash_rdata
);
  logic [7:0] mem [DEPTH];
  // Word on request, inverse of the last value otherwise
  always_ff @(posedge hclk) begin
    if (flash_req) begin
      flash_rdata <= {mem[flash_addr % DEPTH], mem[(flash_addr + 1) % DEPTH]};
    end else begin
      flash_rdata <= ~flash_rdata;
    end
  end
endmodule
`default_nettype wire

// file: bench/tb_flash_crc_scan_engine.sv
// Purpose: Self-checking bench for the flash checksum scanner
// Assumes: Bench is bus master and debugger, flash model on the fetch port
// Notes:   Flash bytes and section sizes come from a fixed-seed LFSR
`timescale 1ns/10ps
`default_nettype none
module tb_flash_crc_scan_engine
  import fcs_pkg::*;
;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, boot_scan_en, cpu_sleep;
  logic        dbg_mem_access, dbg_reg_access, dbg_disconnect, dbg_status_read, dbg_wr_stb;
  logic        flash_req, cpu_stall, irq_hold, nmi_req;
  logic [1:0]  htrans, boot_scan_section_fuse, dbg_wr_idx, dbg_status;
  logic [7:0]  boot_end_fuse, app_end_fuse, dbg_wr_data;
  logic [15:0] last_flash_address, flash_addr, flash_rdata, seed;
  logic [31:0] haddr, hwdata, hrdata, rdv;
  int          num_errors, checked;
  fcs_scanner #(.AW(16)) fcs_scanner_inst (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hready(hreadyout), .hwdata(hwdata),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .boot_scan_en(boot_scan_en),
    .boot_scan_section_fuse(boot_scan_section_fuse), .boot_end_fuse(boot_end_fuse),
    .app_end_fuse(app_end_fuse), .last_flash_address(last_flash_address),
    .cpu_sleep(cpu_sleep), .dbg_mem_access(dbg_mem_access), .dbg_reg_access(dbg_reg_access),
    .dbg_disconnect(dbg_disconnect), .dbg_status_read(dbg_status_read),
    .dbg_wr_stb(dbg_wr_stb), .dbg_wr_idx(dbg_wr_idx), .dbg_wr_data(dbg_wr_data),
    .dbg_status(dbg_status), .flash_req(flash_req), .flash_addr(flash_addr),
    .flash_rdata(flash_rdata), .cpu_stall(cpu_stall), .irq_hold(irq_hold), .nmi_req(nmi_req)
  );
  fcs_flash_model #(.AW(16), .DEPTH(1024)) fcs_flash_model_inst (
    .hclk(hclk), .flash_req(flash_req), .flash_addr(flash_addr), .flash_rdata(flash_rdata)
  );
  // 25 MHz clock
  initial begin
    hclk = 1'b0;
    forever #20 hclk = ~hclk;
  end
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  // Last byte of each section
  function automatic int sec_end(input logic [1:0] s);
    case (s)
      2'h2:    return int'(boot_end_fuse) * 256 - 1;
      2'h1:    return int'(app_end_fuse) * 256 - 1;
      default: return int'(last_flash_address);
    endcase
  endfunction
  // Store a good or broken checksum in the section's last two bytes
  task automatic prep(input logic [1:0] s, input logic good);
    int e;
    logic [15:0] c;
    begin
      e = sec_end(s);
      c = 16'hffff;
      for (int i = 0; i < e - 1; i++) begin
        c = c ^ {fcs_flash_model_inst.mem[i], 8'h00};
        for (int b = 0; b < 8; b++) begin
          c = c[15] ? ({c[14:0], 1'b0} ^ 16'h1021) : {c[14:0], 1'b0};
        end
      end
      fcs_flash_model_inst.mem[e - 1] = c[15:8];
      fcs_flash_model_inst.mem[e] = good ? c[7:0] : ~c[7:0];
    end
  endtask
  task automatic tally_and_finish;
    if (num_errors == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic fail_to;
    $display("unexpected at %0t: wait timed out", $time);
    num_errors++;
    tally_and_finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge hclk);
  endtask
  // Bounded wait for hready; a silent bus ends the run
  task automatic wait_rdy;
    int n;
    begin
      n = 0;
      tick(1);
      while (hreadyout !== 1'b1) begin
        n++;
        if (n > 50) fail_to;
        tick(1);
      end
    end
  endtask
  // Single word transfer: address phase, then data phase
  task automatic ahb(input logic wr, input logic [1:0] idx, input logic [7:0] wd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {28'h000_0000, idx, 2'h0};
    wait_rdy;
    htrans <= 2'h0;
    hwdata <= {24'h00_0000, wd};
    wait_rdy;
    rdv = hrdata;
  endtask
  task automatic rd(input logic [1:0] idx, input logic [7:0] exp);
    ahb(1'b0, idx, 8'h00);
    chk(rdv, {24'h00_0000, exp});
    chk({31'h0, hresp}, 32'h0);
  endtask
  task automatic dbg_wr(input logic [1:0] idx, input logic [7:0] d);
    dbg_wr_stb <= 1'b1;
    dbg_wr_idx <= idx;
    dbg_wr_data <= d;
    tick(1);
    dbg_wr_stb <= 1'b0;
  endtask
  // Busy is polled with a bound; a scan of the whole array fits easily
  task automatic wait_idle;
    int n;
    begin
      n = 0;
      tick(2);
      while (dbg_status[0] !== 1'b0) begin
        n++;
        if (n > 5000) fail_to;
        tick(1);
      end
    end
  endtask
  initial begin
    num_errors = 0;
    checked = 0;
    seed = 16'hd7d5;
    {hresetn, hsel, hwrite, boot_scan_en, cpu_sleep, dbg_mem_access, dbg_reg_access,
     dbg_disconnect, dbg_status_read, dbg_wr_stb, htrans, dbg_wr_idx, dbg_wr_data,
     boot_scan_section_fuse, haddr, hwdata} = '0;
    for (int i = 0; i < 1024; i++) begin
      seed = lfsr(seed);
      fcs_flash_model_inst.mem[i] = seed[7:0];
    end
    boot_end_fuse = 8'h01 + {7'h00, seed[8]};
    app_end_fuse = boot_end_fuse + 8'h01;
    last_flash_address = {app_end_fuse, 8'hff};
    tick(8);
    hresetn <= 1'b1;
    tick(1);
    // Reset values and the unmapped word
    rd(2'h0, 8'h00);
    rd(2'h1, 8'h00);
    rd(2'h2, 8'h02);
    rd(2'h3, 8'h00);
    // Every section select with a correct checksum
    for (int s = 2; s >= 0; s--) begin
      prep(2'(s), 1'b1);
      ahb(1'b1, 2'h1, 8'(s));
      ahb(1'b1, 2'h0, 8'h01);
      wait_idle;
      rd(2'h2, 8'h02);
      rd(2'h1, 8'(s));
      rd(2'h0, 8'h01);
    end
    ahb(1'b1, 2'h0, 8'h00);
    rd(2'h0, 8'h01);
    // Debugger holds the scan, disconnect restarts it
    prep(2'h2, 1'b1);
    ahb(1'b1, 2'h1, 8'h02);
    ahb(1'b1, 2'h0, 8'h01);
    tick(20);
    dbg_mem_access <= 1'b1;
    tick(30);
    chk({31'h0, dbg_status[0]}, 32'h1);
    chk({31'h0, cpu_stall}, 32'h1);
    ahb(1'b1, 2'h1, 8'h01);
    dbg_mem_access <= 1'b0;
    {dbg_disconnect, dbg_status_read, dbg_reg_access} <= 3'h7;
    tick(4);
    {dbg_disconnect, dbg_status_read, dbg_reg_access} <= 3'h0;
    wait_idle;
    rd(2'h2, 8'h02);
    rd(2'h1, 8'h02);
    // Debugger abort, then strobe and pass set while idle
    ahb(1'b1, 2'h0, 8'h01);
    tick(20);
    dbg_wr(2'h2, 8'h02);
    tick(40);
    chk({31'h0, dbg_status[0]}, 32'h0);
    ahb(1'b1, 2'h0, 8'h80);
    rd(2'h0, 8'h00);
    rd(2'h2, 8'h00);
    dbg_wr(2'h2, 8'h02);
    rd(2'h2, 8'h02);
    // Sleep mid-scan halts, wake resumes
    prep(2'h0, 1'b1);
    ahb(1'b1, 2'h0, 8'h03);
    tick(30);
    cpu_sleep <= 1'b1;
    tick(30);
    chk({31'h0, dbg_status[0]}, 32'h1);
    chk({31'h0, irq_hold}, 32'h1);
    ahb(1'b1, 2'h0, 8'h80);
    tick(2);
    chk({31'h0, dbg_status[0]}, 32'h1);
    cpu_sleep <= 1'b0;
    wait_idle;
    rd(2'h2, 8'h02);
    // Broken checksum with the failure interrupt armed
    prep(2'h0, 1'b0);
    ahb(1'b1, 2'h0, 8'h03);
    wait_idle;
    rd(2'h2, 8'h00);
    chk({31'h0, nmi_req}, 32'h1);
    ahb(1'b1, 2'h1, 8'h01);
    ahb(1'b1, 2'h0, 8'h80);
    rd(2'h1, 8'h00);
    rd(2'h0, 8'h03);
    // Reset-time boot scan, good then broken
    for (int g = 1; g >= 0; g--) begin
      prep(2'h2, 1'(g));
      hresetn <= 1'b0;
      boot_scan_en <= 1'b1;
      boot_scan_section_fuse <= 2'h2;
      tick(2);
      hresetn <= 1'b1;
      tick(1);
      wait_idle;
      rd(2'h0, 8'h01);
      rd(2'h1, 8'h02);
      rd(2'h2, {6'h00, 1'(g), 1'b0});
      chk({30'h0, nmi_req, cpu_stall}, {31'h0, ~1'(g)});
    end
    tally_and_finish;
  end
endmodule
`default_nettype wire
